//--- inc/adcseq_map.vh
// constant map of the adc conversion sequencer: offsets, fields, resets, timings
`ifndef ADCSEQ_MAP_VH
`define ADCSEQ_MAP_VH
// ==========================================================
// register byte offsets
`define ADCSEQ_OFF_CTL0 12'h000
`define ADCSEQ_OFF_CTL1 12'h004
`define ADCSEQ_OFF_STATUS 12'h008
`define ADCSEQ_OFF_IRQ_STAT 12'h00c
`define ADCSEQ_OFF_IRQ_MASK 12'h010
`define ADCSEQ_OFF_RESULT 12'h014
`define ADCSEQ_OFF_SAMPLE 12'h018
// ==========================================================
// converter_control_zero fields
`define ADCSEQ_C0_ENABLE 0
`define ADCSEQ_C0_POWER 1
`define ADCSEQ_C0_START 2
// converter_control_one fields
`define ADCSEQ_C1_PULSE 0
`define ADCSEQ_C1_TRIGSRC 1
`define ADCSEQ_C1_SEQ_LO 2
`define ADCSEQ_C1_SEQ_HI 3
`define ADCSEQ_C1_VR_LO 4
`define ADCSEQ_C1_VR_HI 7
`define ADCSEQ_C1_LEN_LO 8
`define ADCSEQ_C1_LEN_HI 11
// status fields
`define ADCSEQ_ST_BUSY 0
`define ADCSEQ_ST_HALTED 1
`define ADCSEQ_ST_BADRES 2
// interrupt bits
`define ADCSEQ_IRQ_DONE 0
`define ADCSEQ_IRQ_SEQEND 1
`define ADCSEQ_IRQ_TOV 2
`define ADCSEQ_IRQ_HALT 3
`define ADCSEQ_IRQ_W 4
// ==========================================================
// sequence modes
`define ADCSEQ_MODE_SINGLE 2'h0
`define ADCSEQ_MODE_SEQ 2'h1
`define ADCSEQ_MODE_RPT_SINGLE 2'h2
`define ADCSEQ_MODE_RPT_SEQ 2'h3
// ==========================================================
// reset values and timing
`define ADCSEQ_RST_SAMPLE 8'h04
`define ADCSEQ_MIN_EXT_SAMPLE 8'h06
`define ADCSEQ_CONV_CYCLES 8'h0e
`endif

//--- verilog/adcseq_timer.v
// sample-then-convert cycle counter of the adc sequencer
`timescale 1ns/100ps
`default_nettype none
module adcseq_timer #(
  parameter W = 8
) (
  // clock and reset
  input wire core_clk,
  input wire reset_n,
  input wire clk_en,
  // control
  input wire start,
  input wire abort,
  input wire [W-1:0] sample_cycles,
  input wire [W-1:0] conv_cycles,
  // status
  output reg running,
  output reg sampling,
  output reg done
);
  reg [W-1:0] count;
  // ==========================================================
  // sample phase followed by conversion phase, done pulses one cycle
  always @(posedge core_clk) begin
    if (!reset_n) begin
      running <= 1'b0;
      sampling <= 1'b0;
      done <= 1'b0;
      count <= {W{1'b0}};
    end else if (clk_en) begin
      done <= 1'b0;
      if (abort) begin
        running <= 1'b0;
        sampling <= 1'b0;
      end else if (start && !running) begin
        running <= 1'b1;
        sampling <= 1'b1;
        count <= (sample_cycles == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : sample_cycles;
      end else if (running) begin
        if (count > {{(W-1){1'b0}}, 1'b1}) begin
          count <= count - {{(W-1){1'b0}}, 1'b1};
        end else if (sampling) begin
          sampling <= 1'b0;
          count <= conv_cycles;
        end else begin
          running <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- verilog/adcseq_core.v
// adc conversion sequencer with apb registers, dma request and irq
// Function
// - new trigger while busy in sequence or repeat modes halts conversions until recovered
// - timer overflow flag stays clear for triggers that cause the halt
// - sequence modes raise a dma request after every single conversion
// - dma single transfer per conversion, in single modes only with sequence length zero; completion only at sequence end
// - extended mode, unbuffered reference, sample under six cycles gives wrong result
`timescale 1ns/100ps
`default_nettype none
`include "adcseq_map.vh"
module adcseq_core #(
  parameter RES_W = 12
) (
  // clock and reset
  input wire core_clk,
  input wire reset_n,
  input wire clk_en,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // trigger timer and analog data
  input wire timer_trigger,
  input wire [RES_W-1:0] analog_code,
  // dma
  output reg dma_req,
  input wire dma_ack,
  output reg [RES_W-1:0] dma_data,
  // interrupt
  output reg irq
);
  // ==========================================================
  // state encodings
  localparam ST_OFF = 4'b0001;
  localparam ST_IDLE = 4'b0010;
  localparam ST_CONV = 4'b0100;
  localparam ST_HALT = 4'b1000;

  reg [3:0] state;
  reg enable_bit;
  reg power_bit;
  reg pulse_bit;
  reg trig_from_timer;
  reg [1:0] seq_mode;
  reg [3:0] vref_sel;
  reg [3:0] seq_len;
  reg [7:0] sample_cycles;
  reg [3:0] seq_pos;
  reg [RES_W-1:0] result;
  reg bad_result;
  reg [`ADCSEQ_IRQ_W-1:0] irq_stat;
  reg [`ADCSEQ_IRQ_W-1:0] irq_mask;
  reg [`ADCSEQ_IRQ_W-1:0] set_ev;
  reg tmr_start;
  reg tmr_abort;
  reg [31:0] next_rdata;
  wire tmr_running;
  wire tmr_sampling;
  wire tmr_done;
  wire access;
  wire wr;
  wire rd;
  wire start_cmd;
  wire trigger;
  wire hazard_mode;
  wire last_in_seq;
  wire risky;

  // ==========================================================
  // unbuffered reference codes, used only by the suspect-result logic
  function vref_unbuffered;
    input [3:0] sel;
    begin
      vref_unbuffered = (sel == 4'h0) || (sel == 4'h2) || (sel == 4'h4) ||
                        (sel == 4'h6) || (sel == 4'hc) || (sel == 4'he);
    end
  endfunction

  // ==========================================================
  // bus decode; reads latch in the first access cycle, writes land on the answer edge
  assign access = psel && penable && !pready;
  assign wr = psel && penable && pready && pwrite;
  assign rd = access && !pwrite;
  assign start_cmd = wr && (paddr == `ADCSEQ_OFF_CTL0) && pwdata[`ADCSEQ_C0_START];
  // trigger source is either the start command or the timer input
  assign trigger = trig_from_timer ? timer_trigger : start_cmd;
  // halting hazard applies to all modes except plain single channel
  assign hazard_mode = (seq_mode != `ADCSEQ_MODE_SINGLE);
  assign last_in_seq = (seq_pos == seq_len);
  // extended mode plus unbuffered ref plus short sample is flagged
  assign risky = !pulse_bit && vref_unbuffered(vref_sel) && (sample_cycles < `ADCSEQ_MIN_EXT_SAMPLE);

  adcseq_timer #(
    .W(8)
  ) u_timer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .start(tmr_start),
    .abort(tmr_abort),
    .sample_cycles(sample_cycles),
    .conv_cycles(`ADCSEQ_CONV_CYCLES),
    .running(tmr_running),
    .sampling(tmr_sampling),
    .done(tmr_done)
  );

  // ==========================================================
  // apb response and read mux
  always @* begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      `ADCSEQ_OFF_CTL0: begin
        next_rdata[`ADCSEQ_C0_ENABLE] = enable_bit;
        next_rdata[`ADCSEQ_C0_POWER] = power_bit;
      end
      `ADCSEQ_OFF_CTL1: begin
        next_rdata[`ADCSEQ_C1_PULSE] = pulse_bit;
        next_rdata[`ADCSEQ_C1_TRIGSRC] = trig_from_timer;
        next_rdata[`ADCSEQ_C1_SEQ_HI:`ADCSEQ_C1_SEQ_LO] = seq_mode;
        next_rdata[`ADCSEQ_C1_VR_HI:`ADCSEQ_C1_VR_LO] = vref_sel;
        next_rdata[`ADCSEQ_C1_LEN_HI:`ADCSEQ_C1_LEN_LO] = seq_len;
      end
      `ADCSEQ_OFF_STATUS: begin
        // software polls this busy bit before a manual start
        next_rdata[`ADCSEQ_ST_BUSY] = (state == ST_CONV) || (state == ST_HALT);
        next_rdata[`ADCSEQ_ST_HALTED] = (state == ST_HALT);
        next_rdata[`ADCSEQ_ST_BADRES] = bad_result;
      end
      `ADCSEQ_OFF_IRQ_STAT: next_rdata[`ADCSEQ_IRQ_W-1:0] = irq_stat;
      `ADCSEQ_OFF_IRQ_MASK: next_rdata[`ADCSEQ_IRQ_W-1:0] = irq_mask;
      `ADCSEQ_OFF_RESULT: next_rdata[RES_W-1:0] = result;
      `ADCSEQ_OFF_SAMPLE: next_rdata[7:0] = sample_cycles;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      pready <= access;
      pslverr <= access && (paddr > `ADCSEQ_OFF_SAMPLE || paddr[1:0] != 2'h0);
      prdata <= rd ? next_rdata : 32'h0000_0000;
    end
  end

  // ==========================================================
  // control register writes
  always @(posedge core_clk) begin
    if (!reset_n) begin
      enable_bit <= 1'b0;
      power_bit <= 1'b0;
      pulse_bit <= 1'b0;
      trig_from_timer <= 1'b0;
      seq_mode <= `ADCSEQ_MODE_SINGLE;
      vref_sel <= 4'h0;
      seq_len <= 4'h0;
      sample_cycles <= `ADCSEQ_RST_SAMPLE;
      irq_mask <= {`ADCSEQ_IRQ_W{1'b0}};
    end else if (clk_en && wr) begin
      case (paddr)
        `ADCSEQ_OFF_CTL0: begin
          enable_bit <= pwdata[`ADCSEQ_C0_ENABLE];
          power_bit <= pwdata[`ADCSEQ_C0_POWER];
        end
        `ADCSEQ_OFF_CTL1: begin
          // mode fields only change while conversions are disabled
          if (!enable_bit) begin
            pulse_bit <= pwdata[`ADCSEQ_C1_PULSE];
            trig_from_timer <= pwdata[`ADCSEQ_C1_TRIGSRC];
            seq_mode <= pwdata[`ADCSEQ_C1_SEQ_HI:`ADCSEQ_C1_SEQ_LO];
            vref_sel <= pwdata[`ADCSEQ_C1_VR_HI:`ADCSEQ_C1_VR_LO];
            seq_len <= pwdata[`ADCSEQ_C1_LEN_HI:`ADCSEQ_C1_LEN_LO];
          end
        end
        `ADCSEQ_OFF_IRQ_MASK: irq_mask <= pwdata[`ADCSEQ_IRQ_W-1:0];
        `ADCSEQ_OFF_SAMPLE: sample_cycles <= pwdata[7:0];
        default: irq_mask <= irq_mask;
      endcase
    end
  end

  // ==========================================================
  // conversion state machine
  always @(posedge core_clk) begin
    if (!reset_n) begin
      state <= ST_OFF;
      seq_pos <= 4'h0;
      result <= {RES_W{1'b0}};
      bad_result <= 1'b0;
      dma_req <= 1'b0;
      dma_data <= {RES_W{1'b0}};
      tmr_start <= 1'b0;
      tmr_abort <= 1'b0;
      set_ev <= {`ADCSEQ_IRQ_W{1'b0}};
    end else if (clk_en) begin
      tmr_start <= 1'b0;
      tmr_abort <= 1'b0;
      set_ev <= {`ADCSEQ_IRQ_W{1'b0}};
      if (dma_ack) begin
        dma_req <= 1'b0;
      end
      case (state)
        ST_OFF: begin
          // halt is left only with power and enable both off; power on, enable then restart
          if (power_bit) begin
            state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (!power_bit) begin
            state <= ST_OFF;
          end else if (trigger && (start_cmd ? pwdata[`ADCSEQ_C0_ENABLE] : enable_bit)) begin
            state <= ST_CONV;
            seq_pos <= 4'h0;
            tmr_start <= 1'b1;
          end
        end
        ST_CONV: begin
          if (hazard_mode && trigger) begin
            // overlap kills the sequence; no overflow flag is raised
            state <= ST_HALT;
            tmr_abort <= 1'b1;
            set_ev[`ADCSEQ_IRQ_HALT] <= 1'b1;
          end else if (!trig_from_timer && trigger) begin
            // single mode overlap of a start command is counted as a timer overflow event
            set_ev[`ADCSEQ_IRQ_TOV] <= 1'b1;
          end else if (!enable_bit && !tmr_running) begin
            state <= ST_IDLE;
          end else if (tmr_done) begin
            result <= analog_code;
            bad_result <= risky;
            dma_data <= analog_code;
            set_ev[`ADCSEQ_IRQ_DONE] <= 1'b1;
            // sequence modes request dma after every conversion
            if (seq_mode == `ADCSEQ_MODE_SEQ || seq_mode == `ADCSEQ_MODE_RPT_SEQ || last_in_seq) begin
              dma_req <= 1'b1;
            end
            if (seq_mode == `ADCSEQ_MODE_SINGLE || seq_mode == `ADCSEQ_MODE_RPT_SINGLE || last_in_seq) begin
              set_ev[`ADCSEQ_IRQ_SEQEND] <= 1'b1;
              seq_pos <= 4'h0;
            end else begin
              seq_pos <= seq_pos + 4'h1;
            end
            if (seq_mode == `ADCSEQ_MODE_SINGLE || !enable_bit ||
                (seq_mode == `ADCSEQ_MODE_SEQ && last_in_seq)) begin
              state <= ST_IDLE;
            end else begin
              tmr_start <= 1'b1;
            end
          end
        end
        ST_HALT: begin
          if (!power_bit && !enable_bit) begin
            state <= ST_OFF;
          end
        end
        default: state <= ST_OFF;
      endcase
    end
  end

  // ==========================================================
  // sticky status, cleared by reading it; a new event wins over the clear
  always @(posedge core_clk) begin
    if (!reset_n) begin
      irq_stat <= {`ADCSEQ_IRQ_W{1'b0}};
      irq <= 1'b0;
    end else if (clk_en) begin
      if (rd && paddr == `ADCSEQ_OFF_IRQ_STAT) begin
        irq_stat <= set_ev;
      end else begin
        irq_stat <= irq_stat | set_ev;
      end
      irq <= |((irq_stat | set_ev) & irq_mask);
    end
  end
endmodule
`default_nettype wire

//--- sim/adcseq_core_sva.sv
// port assertions of the adc sequencer
`timescale 1ns/100ps
`default_nettype none
module adcseq_core_sva #(
  parameter RES_W = 12
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // dma and irq
  input wire logic dma_req,
  input wire logic dma_ack,
  input wire logic [RES_W-1:0] dma_data,
  input wire logic irq
);
  // ==========================================
  // one domain, so clock and reset are given once
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  pready_pulse_a: assert property (pready |=> !pready) else $error("pready held two cycles");
  apb_answer_a: assert property (psel && penable && !pready |=> pready) else $error("apb answer late");
  read_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero when idle");
  err_qual_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  dma_hold_a: assert property (dma_req && !dma_ack |=> dma_req) else $error("dma request dropped early");
  dma_data_a: assert property (dma_req && !dma_ack |=> $stable(dma_data)) else $error("dma data moved");
  dma_drop_a: assert property (dma_req && dma_ack |-> ##[1:2] !dma_req) else $error("dma request stuck");
  cover property (dma_req && dma_ack);
  cover property (pslverr);
  cover property ($rose(irq));
endmodule
`default_nettype wire

//--- sim/adcseq_dma_model.sv
// dma controller model in single transfer mode, one transfer per request
`timescale 1ns/100ps
`default_nettype none
module adcseq_dma_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // request side
  input wire logic dma_req,
  input wire logic [11:0] dma_data,
  input wire logic [3:0] delay,
  output logic dma_ack,
  output logic [7:0] xfers,
  output logic [11:0] last_data
);
  logic [3:0] cnt;
  logic hold;
  // ==========================================
  // ack after a programmable wait; hold off until the request falls so one request is not taken twice
  always @(posedge core_clk) begin
    dma_ack <= 1'b0;
    if (!reset_n) begin
      cnt <= 4'h0;
      hold <= 1'b0;
      xfers <= 8'h00;
      last_data <= 12'h000;
    end else if (dma_req && !hold) begin
      if (cnt >= delay) begin
        dma_ack <= 1'b1;
        hold <= 1'b1;
        cnt <= 4'h0;
        xfers <= xfers + 8'h01;
        last_data <= dma_data;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end else if (!dma_req) begin
      hold <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- sim/adcseq_core_tb.sv
// self-checking bench of the adc sequencer
`timescale 1ns/100ps
`default_nettype none
`include "adcseq_map.vh"
module adcseq_core_tb;
  logic core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, timer_trigger = 0, clk_en = 1, err;
  logic [11:0] paddr = 12'h000, analog_code = 12'h5a3, last_data;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic pready, pslverr, dma_req, dma_ack, irq;
  logic [11:0] dma_data;
  logic [3:0] delay = 4'h0;
  logic [7:0] xfers, xs;
  int n_fail = 0, compares = 0, cyc = 0, i, j;
  logic [31:0] refs [7] = '{32'h0, 32'h2, 32'h4, 32'h6, 32'hc, 32'he, 32'h1};
  initial forever #12.5 core_clk = ~core_clk;
  adcseq_core u_adcseq_core (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_trigger(timer_trigger), .analog_code(analog_code), .dma_req(dma_req),
    .dma_ack(dma_ack), .dma_data(dma_data), .irq(irq));
  adcseq_dma_model u_adcseq_dma_model (.core_clk(core_clk), .reset_n(reset_n), .dma_req(dma_req),
    .dma_data(dma_data), .delay(delay), .dma_ack(dma_ack), .xfers(xfers), .last_data(last_data));
  // ==========================================
  // reporting
  task complete_run;
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // hang guard, the whole run needs well under this
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      complete_run;
    end
  end
  // ==========================================
  // apb master: request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // software polls busy before the next start
  task wait_idle;
    for (i = 0; i < 60; i++) begin
      apb(1'b0, `ADCSEQ_OFF_STATUS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
  endtask
  task wait_x(input logic [7:0] n);
    for (j = 0; j < 400 && xfers !== n; j++) @(posedge core_clk);
    chk({24'h0, xfers}, {24'h0, n});
  endtask
  // one timer-triggered single conversion, then check the suspect-result bit
  task conv(input logic [31:0] c1, input logic [31:0] smp, input logic [31:0] e);
    apb(1'b1, `ADCSEQ_OFF_CTL0, 32'h2);
    apb(1'b1, `ADCSEQ_OFF_SAMPLE, smp);
    apb(1'b1, `ADCSEQ_OFF_CTL1, c1 | 32'h2);
    apb(1'b1, `ADCSEQ_OFF_CTL0, 32'h3);
    @(posedge core_clk) timer_trigger <= 1'b1;
    @(posedge core_clk) timer_trigger <= 1'b0;
    wait_idle;
    rdc(`ADCSEQ_OFF_STATUS, 32'h4, e);
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    rdc(`ADCSEQ_OFF_SAMPLE, 32'hffffffff, 32'h4);
    rdc(`ADCSEQ_OFF_STATUS, 32'hffffffff, 32'h0);
    rdc(12'h020, 32'hffffffff, 32'h0);
    chk({31'h0, err}, 32'h1);
    // single manual conversion with irq masked, then unmasked
    apb(1'b1, `ADCSEQ_OFF_IRQ_MASK, 32'h0);
    apb(1'b1, `ADCSEQ_OFF_CTL1, 32'h0);
    apb(1'b1, `ADCSEQ_OFF_CTL0, 32'h2);
    apb(1'b1, `ADCSEQ_OFF_CTL0, 32'h7);
    // clock enable low freezes the conversion, so no transfer may appear meanwhile
    clk_en <= 1'b0;
    repeat (60) @(posedge core_clk);
    chk({24'h0, xfers}, 32'h0);
    clk_en <= 1'b1;
    wait_idle;
    wait_x(8'h01);
    chk({31'h0, irq}, 32'h0);
    chk({20'h0, last_data}, {20'h0, analog_code});
    apb(1'b1, `ADCSEQ_OFF_IRQ_MASK, 32'hf);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    rdc(`ADCSEQ_OFF_IRQ_STAT, 32'hf, 32'h3);
    rdc(`ADCSEQ_OFF_IRQ_STAT, 32'hf, 32'h0);
    rdc(`ADCSEQ_OFF_RESULT, 32'hfff, 32'h5a3);
    // sequence of three with a slow dma: one request per conversion
    delay <= 4'h5;
    apb(1'b1, `ADCSEQ_OFF_CTL0, 32'h2);
    apb(1'b1, `ADCSEQ_OFF_CTL1, 32'h204);
    apb(1'b1, `ADCSEQ_OFF_CTL0, 32'h7);
    wait_idle;
    wait_x(8'h04);
    rdc(`ADCSEQ_OFF_IRQ_STAT, 32'h2, 32'h2);
    apb(1'b1, `ADCSEQ_OFF_CTL1, 32'h0);
    rdc(`ADCSEQ_OFF_CTL1, 32'hfff, 32'h204);
    // second start while busy halts the sequence
    apb(1'b1, `ADCSEQ_OFF_CTL0, 32'h7);
    apb(1'b1, `ADCSEQ_OFF_CTL0, 32'h7);
    repeat (100) @(posedge core_clk);
    rdc(`ADCSEQ_OFF_STATUS, 32'h3, 32'h3);
    rdc(`ADCSEQ_OFF_IRQ_STAT, 32'hc, 32'h8);
    // recovery: enable and power off, power on, enable and start
    apb(1'b1, `ADCSEQ_OFF_CTL0, 32'h0);
    xs = xfers;
    apb(1'b1, `ADCSEQ_OFF_CTL0, 32'h2);
    rdc(`ADCSEQ_OFF_STATUS, 32'h3, 32'h0);
    apb(1'b1, `ADCSEQ_OFF_CTL0, 32'h7);
    wait_idle;
    wait_x(xs + 8'h03);
    // single mode overlap sets the overflow flag instead
    apb(1'b1, `ADCSEQ_OFF_CTL0, 32'h2);
    apb(1'b1, `ADCSEQ_OFF_CTL1, 32'h0);
    apb(1'b1, `ADCSEQ_OFF_CTL0, 32'h7);
    apb(1'b1, `ADCSEQ_OFF_CTL0, 32'h7);
    wait_idle;
    rdc(`ADCSEQ_OFF_IRQ_STAT, 32'h4, 32'h4);
    // extended mode with short sampling on every unbuffered reference and one buffered, then pulse mode and a six-cycle sample
    for (int k = 0; k < 7; k++) conv(refs[k] << 4, 32'h4, (k < 6) ? 32'h4 : 32'h0);
    conv(32'h1, 32'h4, 32'h0);
    conv(32'h0, 32'h6, 32'h0);
    complete_run;
  end
endmodule
bind adcseq_core adcseq_core_sva #(.RES_W(RES_W)) u_adcseq_core_sva (.core_clk(core_clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dma_req(dma_req),
  .dma_ack(dma_ack), .dma_data(dma_data), .irq(irq));
`default_nettype wire
